// ===== hw/msc_cfg_nv.v
// nonvolatile configuration byte with shared program and erase timer
`timescale 1ns/1ps
`include "msc_consts.vh"
module msc_cfg_nv #(
  parameter PROG_CYCLES = `MSC_PROG_CYCLES
) (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       erase_req,
  input  wire       prog_req,
  input  wire [7:0] prog_data,
  output reg  [7:0] nv_q,
  output reg        busy_q
);

  reg [31:0] timer_q;
  reg        erase_q;
  reg [7:0]  data_q;

  // ----------------------------------------------------------------
  // cell contents survive reset; only power-up, program and erase set them
  // ----------------------------------------------------------------
  initial nv_q = `MSC_CFG_NV_INIT;

  always @(posedge clk_sys) begin
    if (busy_q && !sys_rst && timer_q == 32'h0000_0001) begin
      if (erase_q) begin
        nv_q <= `MSC_CFG_ERASED;
      end else begin
        nv_q <= nv_q & data_q;
      end
    end
  end

  // reset aborts an operation; the cell is then left unchanged
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q  <= 1'b0;
      timer_q <= 32'h0000_0000;
      erase_q <= 1'b0;
      data_q  <= 8'hff;
    end else if (busy_q) begin
      timer_q <= timer_q - 32'h0000_0001;
      if (timer_q == 32'h0000_0001) begin
        busy_q <= 1'b0;
      end
    end else if (erase_req || prog_req) begin
      busy_q  <= 1'b1;
      timer_q <= PROG_CYCLES;
      erase_q <= erase_req;
      data_q  <= prog_data;
    end
  end

endmodule

// ===== hw/msc_consts.vh
// constants for the mode select and configuration latch block
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MSC_ADR_PMC        4'h0
`define MSC_ADR_CFG        4'h4
`define MSC_ADR_NVC        4'h8
`define MSC_ADR_STAT       4'hc

// ----------------------------------------------------------------
// priority_and_mode_control fields
// ----------------------------------------------------------------
`define MSC_PMC_BOOT       7
`define MSC_PMC_SPECIAL_MODE_FLAG       6
`define MSC_PMC_MDA        5
`define MSC_PMC_IRV        4
`define MSC_PSEL_RST       4'h0

// ----------------------------------------------------------------
// configuration byte
// ----------------------------------------------------------------
`define MSC_CFG_SECURITY_DISABLE_BIT      3
`define MSC_CFG_ERASED     8'hff
`define MSC_CFG_NV_INIT    8'h0f

// ----------------------------------------------------------------
// nonvolatile control register fields
// ----------------------------------------------------------------
`define MSC_NVC_ERASE      0
`define MSC_NVC_PROG       1
`define MSC_NVC_BUSY       2

// ----------------------------------------------------------------
// bootstrap firmware window
// ----------------------------------------------------------------
`define MSC_BOOT_BYTES     192
`define MSC_BOOT_BASE      16'hbf40

// ----------------------------------------------------------------
// timing: program or erase time and the clock rate
// ----------------------------------------------------------------
`define MSC_PROG_TIME_US   10000
`define MSC_CLK_MHZ        100
`define MSC_PROG_CYCLES    (`MSC_PROG_TIME_US * `MSC_CLK_MHZ)

`endif

// ===== hw/msc_sync3.v
// three-flop pin synchroniser with a hold-until-agree filter
`timescale 1ns/1ps
module msc_sync3 #(
  parameter WIDTH = 2
) (
  input  wire             clk_sys,
  input  wire             track,
  input  wire [WIDTH-1:0] pin_i,
  output reg  [WIDTH-1:0] level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // ----------------------------------------------------------------
  // no reset here: the chain must keep sampling while reset is held
  // ----------------------------------------------------------------
  initial level_q = {WIDTH{1'b0}};

  always @(posedge clk_sys) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (track && (s2_q == s3_q)) begin
      level_q <= s3_q;
    end
  end

endmodule

// ===== hw/msc_top.v
// mode select, protected mode bits and configuration latch
`timescale 1ns/1ps
`include "msc_consts.vh"
module msc_top #(
  parameter PROG_CYCLES   = `MSC_PROG_CYCLES,
  parameter CFG_DIRECT_WR = 1
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // strap pins; mode a is shared with the fetch marker
  input  wire        mode_a_strap_i,
  input  wire        mode_b_strap_i,
  output reg         fetch_marker_o,
  output reg         fetch_marker_oe,
  // processor side
  input  wire        instr_start_i,
  input  wire        int_read_i,
  input  wire [7:0]  int_rdata_i,
  input  wire [15:0] cpu_addr_i,
  // external data bus drive
  output reg  [7:0]  ext_data_o,
  output reg         ext_data_oe,
  // mode and configuration state
  output reg         boot_rom_sel_o,
  output reg         boot_rom_map_o,
  output reg         special_mode_o,
  output reg         mode_a_select_o,
  output reg         read_visible_o,
  output reg  [3:0]  cfg_work_o
);

  // ----------------------------------------------------------------
  // local state
  // ----------------------------------------------------------------
  localparam [31:0] BOOT_END  = `MSC_BOOT_BASE + `MSC_BOOT_BYTES - 1;
  localparam [15:0] BOOT_LAST = BOOT_END[15:0];

  wire [1:0] strap_lvl;
  wire [7:0] nv_byte;
  wire       nv_busy;

  reg        boot_rom_enable_q;
  reg        special_mode_flag_q;
  reg        mode_a_select_q;
  reg        internal_read_visible_q;
  reg [3:0]  priority_select_field_q;
  reg [3:0]  cfg_work_q;
  reg        ack_q;
  reg [31:0] rdata_q;
  reg        nv_erase_q;
  reg        nv_prog_q;
  reg [7:0]  nv_data_q;

  reg        boot_d;
  reg        special_mode_flag_d;
  reg        mda_d;
  reg        irv_d;
  reg [3:0]  psel_d;
  reg [3:0]  cfg_d;

  wire       bus_req;
  wire       wr_stb;
  wire       rd_stb;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [7:0] pmc_image;
    input       boot;
    input       special_mode_flag;
    input       mode_a_select;
    input       internal_read_visible;
    input [3:0] psel;
    begin
      pmc_image = {boot, special_mode_flag, mode_a_select, internal_read_visible, psel};
    end
  endfunction

  // byte select by lane enable; used for byte lane 1, the program data byte
  function [7:0] lane0_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input       lane;
    begin
      lane0_merge = lane ? new_v : old_v;
    end
  endfunction

  // ----------------------------------------------------------------
  // strap synchroniser: tracks only while reset is held
  // ----------------------------------------------------------------
  msc_sync3 #(
    .WIDTH (2)
  ) u_strap (
    .clk_sys (clk_sys),
    .track   (sys_rst),
    .pin_i   ({mode_b_strap_i, mode_a_strap_i}),
    .level_q (strap_lvl)
  );

  // ----------------------------------------------------------------
  // nonvolatile configuration cell
  // ----------------------------------------------------------------
  msc_cfg_nv #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_nv (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .erase_req (nv_erase_q),
    .prog_req  (nv_prog_q),
    .prog_data (nv_data_q),
    .nv_q      (nv_byte),
    .busy_q    (nv_busy)
  );

  // ----------------------------------------------------------------
  // wishbone handshake
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_stb  = bus_req & wb_we_i;
  assign rd_stb  = bus_req & ~wb_we_i;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // ----------------------------------------------------------------
  // mode bit next state
  // ----------------------------------------------------------------
  // while reset is held the bits follow the filtered straps, so the
  // value left at release is the one seen just before it
  always @* begin
    boot_d = boot_rom_enable_q;
    special_mode_flag_d = special_mode_flag_q;
    mda_d  = mode_a_select_q;
    irv_d  = internal_read_visible_q;
    psel_d = priority_select_field_q;
    if (sys_rst) begin
      case (strap_lvl)
        2'b10: begin
          boot_d = 1'b0;
          special_mode_flag_d = 1'b0;
          irv_d  = 1'b0;
        end
        2'b11: begin
          boot_d = 1'b0;
          special_mode_flag_d = 1'b0;
          irv_d  = 1'b0;
        end
        2'b00: begin
          boot_d = 1'b1;
          special_mode_flag_d = 1'b1;
          irv_d  = 1'b1;
        end
        default: begin
          boot_d = 1'b0;
          special_mode_flag_d = 1'b1;
          irv_d  = 1'b1;
        end
      endcase
      mda_d  = strap_lvl[0] & nv_byte[`MSC_CFG_SECURITY_DISABLE_BIT];
      psel_d = `MSC_PSEL_RST;
    end else if (wr_stb && wb_sel_i[0] &&
                 wb_adr_i == `MSC_ADR_PMC) begin
      psel_d = wb_dat_i[3:0];
      if (special_mode_flag_q) begin
        boot_d = wb_dat_i[`MSC_PMC_BOOT];
        mda_d  = wb_dat_i[`MSC_PMC_MDA];
        irv_d  = wb_dat_i[`MSC_PMC_IRV];
      end
      if (!wb_dat_i[`MSC_PMC_SPECIAL_MODE_FLAG]) begin
        special_mode_flag_d = 1'b0;
      end
    end
    if (!sys_rst && !special_mode_flag_d) begin
      irv_d = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    boot_rom_enable_q       <= boot_d;
    special_mode_flag_q     <= special_mode_flag_d;
    mode_a_select_q         <= mda_d;
    internal_read_visible_q <= irv_d;
    priority_select_field_q <= psel_d;
  end

  // ----------------------------------------------------------------
  // configuration working register
  // ----------------------------------------------------------------
  // upper nibble has no storage at all
  always @* begin
    cfg_d = cfg_work_q;
    if (sys_rst) begin
      cfg_d = nv_byte[3:0];
    end else if (CFG_DIRECT_WR != 0 && special_mode_flag_q &&
                 wr_stb && wb_sel_i[0] &&
                 wb_adr_i == `MSC_ADR_CFG) begin
      cfg_d = wb_dat_i[3:0];
    end
  end

  always @(posedge clk_sys) begin
    cfg_work_q <= cfg_d;
  end

  // ----------------------------------------------------------------
  // program and erase requests
  // ----------------------------------------------------------------
  // requests made while busy are dropped, not queued
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      nv_erase_q <= 1'b0;
      nv_prog_q  <= 1'b0;
      nv_data_q  <= 8'hff;
    end else begin
      nv_erase_q <= 1'b0;
      nv_prog_q  <= 1'b0;
      if (wr_stb && wb_sel_i[0] && wb_adr_i == `MSC_ADR_NVC &&
          !nv_busy && !nv_erase_q && !nv_prog_q) begin
        nv_erase_q <= wb_dat_i[`MSC_NVC_ERASE];
        nv_prog_q  <= wb_dat_i[`MSC_NVC_PROG] &
                      ~wb_dat_i[`MSC_NVC_ERASE];
        nv_data_q  <= lane0_merge(8'hff, wb_dat_i[15:8],
                                  wb_sel_i[1]);
      end
    end
  end

  // ----------------------------------------------------------------
  // read data; unmapped offsets answer zero
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (wb_adr_i)
        `MSC_ADR_PMC: begin
          rdata_q <= {24'h00_0000,
                      pmc_image(boot_rom_enable_q,
                                special_mode_flag_q,
                                mode_a_select_q,
                                internal_read_visible_q,
                                priority_select_field_q)};
        end
        `MSC_ADR_CFG: begin
          rdata_q <= {28'h000_0000, cfg_work_q};
        end
        `MSC_ADR_NVC: begin
          rdata_q <= {16'h0000, nv_data_q, 5'h00, nv_busy,
                      nv_prog_q, nv_erase_q};
        end
        `MSC_ADR_STAT: begin
          rdata_q <= {29'h0000_0000, nv_busy, strap_lvl};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  always @* begin
    wb_ack_o = ack_q;
    wb_dat_o = rdata_q;
  end

  // ----------------------------------------------------------------
  // shared pin: fetch marker only outside reset
  // ----------------------------------------------------------------
  // open drain: the pin is only ever pulled low, never driven high
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      fetch_marker_o  <= 1'b0;
      fetch_marker_oe <= 1'b0;
    end else begin
      fetch_marker_o  <= 1'b0;
      fetch_marker_oe <= instr_start_i;
    end
  end

  // ----------------------------------------------------------------
  // internal read visibility
  // ----------------------------------------------------------------
  // contention with outside drivers is the user's problem here
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_data_o  <= 8'h00;
      ext_data_oe <= 1'b0;
    end else begin
      ext_data_o  <= int_rdata_i;
      ext_data_oe <= internal_read_visible_q & int_read_i;
    end
  end

  // ----------------------------------------------------------------
  // bootstrap rom decode and state outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      boot_rom_sel_o  <= 1'b0;
      boot_rom_map_o  <= 1'b0;
      special_mode_o  <= 1'b0;
      mode_a_select_o <= 1'b0;
      read_visible_o  <= 1'b0;
      cfg_work_o      <= 4'h0;
    end else begin
      boot_rom_sel_o  <= boot_rom_enable_q &
                         (cpu_addr_i >= `MSC_BOOT_BASE) &
                         (cpu_addr_i <= BOOT_LAST);
      boot_rom_map_o  <= boot_rom_enable_q;
      special_mode_o  <= special_mode_flag_q;
      mode_a_select_o <= mode_a_select_q;
      read_visible_o  <= internal_read_visible_q;
      cfg_work_o      <= cfg_work_q;
    end
  end

endmodule

// ===== verif/msc_strap_model.sv
// board model: reset source and mode strap pins
`timescale 1ns/1ps
module msc_strap_model (
  input  wire       clk_sys,
  input  wire       rst_req,
  input  wire [1:0] straps,
  input  wire       fetch_marker_oe,
  output reg        sys_rst,
  output wire       mode_a_strap_i,
  output wire       mode_b_strap_i
);
  reg [2:0] cnt_q;
  reg       drive_q;
  initial begin
    sys_rst = 1'b1;
    cnt_q   = 3'h0;
    drive_q = 1'b1;
  end
  // straps let go at the very edge reset ends: no hold time given
  always @(posedge clk_sys) begin
    if (rst_req) begin
      sys_rst <= 1'b1;
      cnt_q   <= 3'h0;
      drive_q <= 1'b1;
    end else if (sys_rst && cnt_q == 3'h3) begin
      sys_rst <= 1'b0;
      drive_q <= 1'b0;
    end else if (sys_rst) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // mode a pin has a pull-up under the open-drain marker
  // released mode b shows the opposite level, never the strap
  // straps stand from the reset request on, so they clear the pin chain
  assign mode_a_strap_i = (drive_q | rst_req) ? straps[0] : ~fetch_marker_oe;
  assign mode_b_strap_i = (drive_q | rst_req) ? straps[1] : ~straps[1];
endmodule

// ===== verif/msc_top_props.sv
// assertion checker for the mode select and configuration latch
`timescale 1ns/1ps
module msc_top_props (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire        wb_ack_o,
  input wire        fetch_marker_o,
  input wire        fetch_marker_oe,
  input wire        instr_start_i,
  input wire        int_read_i,
  input wire [7:0]  int_rdata_i,
  input wire [15:0] cpu_addr_i,
  input wire [7:0]  ext_data_o,
  input wire        ext_data_oe,
  input wire        boot_rom_sel_o,
  input wire        boot_rom_map_o,
  input wire        special_mode_o,
  input wire        mode_a_select_o,
  input wire        read_visible_o
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // state outputs lag the latch by one edge after reset release
  reg  [1:0] settle_q;
  wire       wr_take;
  wire [3:0] mode_bits;
  assign wr_take   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign mode_bits = {boot_rom_map_o, special_mode_o, mode_a_select_o,
                      read_visible_o};
  always @(posedge clk_sys) begin
    if (sys_rst)
      settle_q <= 2'h0;
    else if (settle_q != 2'h3)
      settle_q <= settle_q + 2'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence req_taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_timing_a: assert property (req_taken_s |=> ack_pulse_s)
    else $error("ack not a single pulse one cycle after request");
  marker_follow_a: assert property (
    1'b1 |=> fetch_marker_oe == $past(instr_start_i))
    else $error("fetch marker enable does not follow instruction start");
  marker_low_a: assert property (!fetch_marker_o)
    else $error("fetch marker drives a high level");
  vis_data_a: assert property (ext_data_oe |->
    $past(int_read_i) && ext_data_o == $past(int_rdata_i))
    else $error("external bus driven without matching internal read");
  vis_block_a: assert property (settle_q == 2'h3 &&
    !read_visible_o && $past(!read_visible_o) |-> !ext_data_oe)
    else $error("external bus driven with visibility off");
  irv_forced_a: assert property (!special_mode_o |-> !read_visible_o)
    else $error("visibility set outside special mode");
  special_mode_flag_sticky_a: assert property (
    settle_q == 2'h3 && !special_mode_o |=> !special_mode_o)
    else $error("special flag set again after clearing");
  straps_ignored_a: assert property (settle_q == 2'h3 &&
    !$past(wr_take) && !$past(wr_take, 2) |-> $stable(mode_bits))
    else $error("mode bits changed without a write");
  boot_window_a: assert property (boot_rom_sel_o |->
    $past(cpu_addr_i) >= 16'hbf40 && $past(cpu_addr_i) <= 16'hbfff)
    else $error("boot rom selected outside its window");
  boot_gate_a: assert property (
    settle_q == 2'h3 && boot_rom_sel_o |-> boot_rom_map_o)
    else $error("boot rom selected while unmapped");
endmodule

bind msc_top msc_top_props msc_top_props_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .fetch_marker_o(fetch_marker_o), .fetch_marker_oe(fetch_marker_oe),
  .instr_start_i(instr_start_i), .int_read_i(int_read_i),
  .int_rdata_i(int_rdata_i), .cpu_addr_i(cpu_addr_i),
  .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
  .boot_rom_sel_o(boot_rom_sel_o), .boot_rom_map_o(boot_rom_map_o),
  .special_mode_o(special_mode_o), .mode_a_select_o(mode_a_select_o),
  .read_visible_o(read_visible_o));

// ===== verif/msc_top_tb_top.sv
// self-checking testbench for the mode select block
`timescale 1ns/1ps
module msc_top_tb_top;
  reg         clk_sys;
  reg         rst_req;
  reg  [1:0]  straps;
  reg         wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [3:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i, sel_v;
  reg  [31:0] wb_dat_i;
  reg         instr_start_i, int_read_i;
  reg  [7:0]  int_rdata_i;
  reg  [15:0] cpu_addr_i;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, sys_rst, mode_a_strap_i, mode_b_strap_i;
  wire        fetch_marker_o, fetch_marker_oe, ext_data_oe;
  wire [7:0]  ext_data_o;
  wire        boot_rom_sel_o, boot_rom_map_o, special_mode_o;
  wire        mode_a_select_o, read_visible_o;
  wire [3:0]  cfg_work_o;
  integer     fail_count, n_compared, i, n;
  reg  [31:0] rd;
  reg  [3:0]  ex;
  reg  [5:0]  rows [0:3];

  msc_strap_model msc_strap_model_i (.clk_sys(clk_sys), .rst_req(rst_req),
    .straps(straps), .fetch_marker_oe(fetch_marker_oe), .sys_rst(sys_rst),
    .mode_a_strap_i(mode_a_strap_i), .mode_b_strap_i(mode_b_strap_i));
  msc_top #(.PROG_CYCLES(8), .CFG_DIRECT_WR(1)) msc_top_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mode_a_strap_i(mode_a_strap_i),
    .mode_b_strap_i(mode_b_strap_i), .fetch_marker_o(fetch_marker_o),
    .fetch_marker_oe(fetch_marker_oe), .instr_start_i(instr_start_i),
    .int_read_i(int_read_i), .int_rdata_i(int_rdata_i),
    .cpu_addr_i(cpu_addr_i), .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe), .boot_rom_sel_o(boot_rom_sel_o),
    .boot_rom_map_o(boot_rom_map_o), .special_mode_o(special_mode_o),
    .mode_a_select_o(mode_a_select_o), .read_visible_o(read_visible_o),
    .cfg_work_o(cfg_work_o));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task give_verdict;
    begin
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // classic cycle: hold everything until ack is sampled high
  task wb(input w, input [3:0] a, input [31:0] d, output [31:0] r);
    integer k;
    begin
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_sel_i <= sel_v;
      wb_adr_i <= a;
      wb_dat_i <= d;
      k = 0;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && k < 16) begin
        @(posedge clk_sys);
        k = k + 1;
      end
      if (k >= 16) begin
        fail_count = fail_count + 1;
        give_verdict;
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      wb_sel_i <= 4'h0;
    end
  endtask
  task do_reset(input [1:0] s);
    integer k;
    begin
      @(posedge clk_sys);
      straps  <= s;
      rst_req <= 1'b1;
      @(posedge clk_sys);
      rst_req <= 1'b0;
      repeat (2) @(posedge clk_sys);
      k = 0;
      while (sys_rst !== 1'b0 && k < 20) begin
        @(posedge clk_sys);
        k = k + 1;
      end
      if (k >= 20) begin
        fail_count = fail_count + 1;
        give_verdict;
      end
      // state outputs settle on the first edge after release
      repeat (2) @(posedge clk_sys);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst_req = 1'b0;
    straps = 2'b10;
    {wb_cyc_i, wb_stb_i, wb_we_i, instr_start_i, int_read_i} = 5'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    sel_v = 4'hf;
    wb_dat_i = 32'h0;
    int_rdata_i = 8'h0;
    cpu_addr_i = 16'h0;
    // {mode_b, mode_a, boot, special, mode a select, visibility}
    rows[0] = 6'h20;
    rows[1] = 6'h32;
    rows[2] = 6'h0d;
    rows[3] = 6'h17;
    for (i = 0; i < 4; i = i + 1) begin
      do_reset(rows[i][5:4]);
      ex = rows[i][3:0];
      wb(1'b0, 4'h0, 32'h0, rd);
      chk(rd, {24'h0, ex, 4'h0});
      chk({boot_rom_map_o, special_mode_o, mode_a_select_o,
           read_visible_o}, ex);
      wb(1'b0, 4'h4, 32'h0, rd);
      chk(rd, 32'h0f);
      wb(1'b1, 4'h0, 32'hf5, rd);
      wb(1'b0, 4'h0, 32'h0, rd);
      chk(rd, ex[2] ? 32'hf5 : {24'h0, ex, 4'h5});
      $display("test mode row %0d done", i);
    end
    wb(1'b1, 4'h4, 32'ha3, rd);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk(rd, 32'h3);
    chk(cfg_work_o, 4'h3);
    wb(1'b0, 4'hc, 32'h0, rd);
    chk(rd, 32'h1);
    $display("test direct config done");
    @(posedge clk_sys);
    {instr_start_i, int_read_i} <= 2'b11;
    int_rdata_i <= 8'h5a;
    cpu_addr_i <= 16'hbf40;
    @(posedge clk_sys);
    {instr_start_i, int_read_i} <= 2'b00;
    cpu_addr_i <= 16'hbf3f;
    #1;
    chk({ext_data_oe, ext_data_o}, 9'h15a);
    chk(fetch_marker_oe, 1'b1);
    chk(boot_rom_sel_o, 1'b1);
    @(posedge clk_sys);
    #1;
    chk({ext_data_oe, fetch_marker_oe, boot_rom_sel_o}, 3'h0);
    $display("test visibility and marker done");
    // software leaves special mode early
    wb(1'b1, 4'h0, 32'ha5, rd);
    wb(1'b0, 4'h0, 32'h0, rd);
    chk(rd, 32'ha5);
    wb(1'b1, 4'h0, 32'hf5, rd);
    wb(1'b1, 4'h4, 32'h0c, rd);
    wb(1'b1, 4'h6, 32'hff, rd);
    // lane 0 off: the low nibble must not change
    sel_v = 4'he;
    wb(1'b1, 4'h0, 32'h0, rd);
    sel_v = 4'hf;
    wb(1'b0, 4'h0, 32'h0, rd);
    chk(rd, 32'ha5);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk(rd, 32'h3);
    wb(1'b0, 4'h2, 32'h0, rd);
    chk(rd, 32'h0);
    @(posedge clk_sys);
    int_read_i <= 1'b1;
    @(posedge clk_sys);
    int_read_i <= 1'b0;
    #1;
    chk(ext_data_oe, 1'b0);
    $display("test normal mode lock done");
    wb(1'b1, 4'h8, 32'h0702, rd);
    rd = 32'h4;
    n = 0;
    while (rd[2] !== 1'b0 && n < 40) begin
      wb(1'b0, 4'h8, 32'h0, rd);
      n = n + 1;
    end
    if (n >= 40) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
    chk(rd[15:8], 8'h07);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk(rd, 32'h3);
    do_reset(2'b11);
    wb(1'b0, 4'h0, 32'h0, rd);
    chk(rd, 32'h0);
    chk(mode_a_select_o, 1'b0);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk(rd, 32'h7);
    $display("test programmed config done");
    give_verdict;
  end
endmodule
